// File: common/sirc_defs.vh
// Constants for the serial-infrared pulse codec
`ifndef SIRC_DEFS_VH
`define SIRC_DEFS_VH

// ==========================================================
// Register map (byte addresses)
`define SIRC_CTRL_OFS        8'h00
`define SIRC_STAT_OFS        8'h04

// ==========================================================
// Control register fields
`define SIRC_CTRL_RATE_LSB   0
`define SIRC_CTRL_RATE_MSB   2
`define SIRC_CTRL_CLKSRC_BIT 3
`define SIRC_CTRL_FIXED_BIT  4
`define SIRC_CTRL_SLEEP_BIT  5
`define SIRC_CTRL_RST_VAL    6'h00

// ==========================================================
// Status register fields
`define SIRC_STAT_OSC_BIT    0
`define SIRC_STAT_TXACT_BIT  1
`define SIRC_STAT_RXACT_BIT  2
`define SIRC_STAT_IRTX_BIT   3
`define SIRC_STAT_URX_BIT    4

// ==========================================================
// Bus responses
`define SIRC_RESP_OKAY       2'b00
`define SIRC_RESP_SLVERR     2'b10

// ==========================================================
// Crystal division per rate code
`define SIRC_DIV_000         7'h02
`define SIRC_DIV_001         7'h04
`define SIRC_DIV_010         7'h0c
`define SIRC_DIV_011         7'h18
`define SIRC_DIV_100         7'h06
`define SIRC_DIV_101         7'h30
`define SIRC_DIV_110         7'h60
`define SIRC_DIV_111         7'h01

// ==========================================================
// Timing in sixteen-times clock ticks and crystal cycles
`define SIRC_ENC_DELAY       4'h7
`define SIRC_ENC_LAST        4'h9
`define SIRC_BIT_LAST        4'hf
`define SIRC_MONO_CYC        3'h6
`define SIRC_DEC_LAST        4'hf

`endif

// File: src/sirc_rate_div.v
// Crystal divider producing the sixteen-times tick
`timescale 1ns/1ps
`include "sirc_defs.vh"

module sirc_rate_div (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       xtal_tick,
	input  wire [2:0] rate_sel,
	output reg        x16_tick
);

	reg  [6:0] div_cnt_ff;
	wire [6:0] div_val;
	reg  [6:0] nxt_div_cnt;
	reg        nxt_x16_tick;

	// ==========================================================
	// Division lookup
	function [6:0] sirc_div_of;
		input [2:0] code;
		begin
			case (code)
				3'h0: sirc_div_of = `SIRC_DIV_000;
				3'h1: sirc_div_of = `SIRC_DIV_001;
				3'h2: sirc_div_of = `SIRC_DIV_010;
				3'h3: sirc_div_of = `SIRC_DIV_011;
				3'h4: sirc_div_of = `SIRC_DIV_100;
				3'h5: sirc_div_of = `SIRC_DIV_101;
				3'h6: sirc_div_of = `SIRC_DIV_110;
				default: sirc_div_of = `SIRC_DIV_111;
			endcase
		end
	endfunction

	assign div_val = sirc_div_of(rate_sel);

	// ==========================================================
	// Counter
	always @* begin
		nxt_div_cnt  = div_cnt_ff;
		nxt_x16_tick = 1'b0;
		if (xtal_tick) begin
			if (div_cnt_ff >= div_val - 7'h01) begin
				nxt_div_cnt  = 7'h00;
				nxt_x16_tick = 1'b1;
			end else begin
				nxt_div_cnt = div_cnt_ff + 7'h01;
			end
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			div_cnt_ff <= 7'h00;
			x16_tick   <= 1'b0;
		end else begin
			div_cnt_ff <= nxt_div_cnt;
			x16_tick   <= nxt_x16_tick;
		end
	end

endmodule

// File: src/sirc_codec.v
// Serial-infrared pulse encoder and decoder with register slave
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "sirc_defs.vh"

// Operation
// - Codec steps on each sixteen-times tick, external or divided crystal.
// - Clock source select high picks the external clock, low the crystal.
// - Codec reset low returns encoder and decoder to idle.
// - Start of a space bit after a mark is a falling edge of transmit data; further spaces start on the 16 tick count wrap.
// - Fixed pulse mode: modulator rising edge fires a six crystal cycle pulse; no pulse with the external clock selected.
// - Fixed pulse width ignores the rate select code.
// - Oscillator sleep stops the oscillator cell and, with the crystal selected, the codec ticks too.
// - Oscillator stops when external clock selected or oscillator sleep high.
// - Codes 000..011 divide crystal by 2, 4, 12, 24.
// - Codes 100..111 divide crystal by 6, 48, 96, or not at all.
// - One pulse per space bit, none per mark bit.
// - After falling edge wait 7 ticks, pulse high 3 ticks, then low.
// - Consecutive spaces give pulses exactly 16 ticks apart.
// - Each falling edge on infrared receive starts a 16 tick stretch.
// - Each received pulse gives a one bit time space on UART receive.
// - Stretched space lasts at least three quarters of a bit time.
module sirc_codec (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        codec_reset_n,
	input  wire        baud_x16_clock,
	input  wire        osc_in,
	input  wire        uart_tx_in,
	input  wire        ir_rx_in_n,
	output reg         ir_tx_out,
	output reg         uart_rx_out,
	output reg         osc_enable,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	localparam ENC_IDLE = 2'b01;
	localparam ENC_BIT  = 2'b10;

	reg  [5:0] ctrl_ff;
	reg        aw_held_ff;
	reg  [7:0] aw_addr_ff;
	reg        w_held_ff;
	reg [31:0] w_data_ff;
	reg  [3:0] w_strb_ff;
	reg        ext_prev_ff;
	reg        osc_prev_ff;
	reg        tx_prev_ff;
	reg        tx_pend_ff;
	reg        rx_prev_ff;
	reg        rx_pend_ff;
	reg  [1:0] enc_state_ff;
	reg  [3:0] enc_cnt_ff;
	reg  [2:0] mono_cnt_ff;
	reg        dec_act_ff;
	reg  [3:0] dec_cnt_ff;
	reg  [1:0] nxt_enc_state;
	reg  [3:0] nxt_enc_cnt;
	reg  [2:0] nxt_mono_cnt;
	reg        nxt_dec_act;
	reg  [3:0] nxt_dec_cnt;
	reg        nxt_ir_tx;
	reg [31:0] nxt_rdata;
	reg  [1:0] nxt_rresp;

	wire [2:0] rate_sel;
	wire       clock_source_select_pin;
	wire       fixed_pulse_select;
	wire       osc_sleep;
	wire       sm_rst;
	wire       ext_tick;
	wire       div_tick;
	wire       x16_tick;
	wire       xtal_tick;
	wire       tx_fall;
	wire       rx_fall;
	wire       mod_rise;
	wire       wr_go;
	wire       rd_go;
	wire [31:0] stat_word;

	assign rate_sel = ctrl_ff[`SIRC_CTRL_RATE_MSB:`SIRC_CTRL_RATE_LSB];
	assign clock_source_select_pin = ctrl_ff[`SIRC_CTRL_CLKSRC_BIT];
	assign fixed_pulse_select      = ctrl_ff[`SIRC_CTRL_FIXED_BIT];
	assign osc_sleep               = ctrl_ff[`SIRC_CTRL_SLEEP_BIT];

	// ==========================================================
	// Register slave
	assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_ff       <= `SIRC_CTRL_RST_VAL;
			aw_held_ff    <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_held_ff     <= 1'b0;
			w_data_ff     <= 32'h00000000;
			w_strb_ff     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SIRC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_ff && !s_axi_awready;
			s_axi_wready  <= !w_held_ff && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SIRC_RESP_OKAY;
				if (aw_addr_ff == `SIRC_CTRL_OFS) begin
					if (w_strb_ff[0])
						ctrl_ff <= w_data_ff[5:0];
				end else if (aw_addr_ff != `SIRC_STAT_OFS) begin
					s_axi_bresp <= `SIRC_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign stat_word = {27'h0000000, uart_rx_out, ir_tx_out, dec_act_ff,
		enc_state_ff[1], osc_enable};

	always @* begin
		nxt_rresp = `SIRC_RESP_OKAY;
		case (s_axi_araddr)
			`SIRC_CTRL_OFS: nxt_rdata = {26'h0000000, ctrl_ff};
			`SIRC_STAT_OFS: nxt_rdata = stat_word;
			default: begin
				nxt_rdata = 32'h00000000;
				nxt_rresp = `SIRC_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SIRC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= nxt_rdata;
				s_axi_rresp  <= nxt_rresp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Oscillator control and clock selection
	always @(posedge core_clk) begin
		if (!rst_n)
			osc_enable <= 1'b1;
		else
			osc_enable <= !(clock_source_select_pin || osc_sleep);
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			ext_prev_ff <= 1'b0;
			osc_prev_ff <= 1'b0;
		end else begin
			ext_prev_ff <= baud_x16_clock;
			osc_prev_ff <= osc_in;
		end
	end

	assign ext_tick  = baud_x16_clock && !ext_prev_ff;
	assign xtal_tick = osc_in && !osc_prev_ff && osc_enable;
	assign x16_tick  = clock_source_select_pin ? ext_tick : div_tick;

	sirc_rate_div u_div (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.xtal_tick (xtal_tick),
		.rate_sel  (rate_sel),
		.x16_tick  (div_tick)
	);

	// ==========================================================
	// Edge capture held until the next tick
	assign sm_rst  = !rst_n || !codec_reset_n;
	assign tx_fall = tx_pend_ff || (tx_prev_ff && !uart_tx_in);
	assign rx_fall = rx_pend_ff || (rx_prev_ff && !ir_rx_in_n);

	always @(posedge core_clk) begin
		if (sm_rst) begin
			tx_prev_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
			tx_pend_ff <= 1'b0;
			rx_pend_ff <= 1'b0;
		end else begin
			tx_prev_ff <= uart_tx_in;
			rx_prev_ff <= ir_rx_in_n;
			tx_pend_ff <= tx_fall && !x16_tick;
			rx_pend_ff <= rx_fall && !x16_tick;
		end
	end

	// ==========================================================
	// Encoder
	always @* begin
		nxt_enc_state = enc_state_ff;
		nxt_enc_cnt   = enc_cnt_ff;
		if (x16_tick) begin
			case (enc_state_ff)
				ENC_IDLE: begin
					if (tx_fall) begin
						nxt_enc_state = ENC_BIT;
						nxt_enc_cnt   = 4'h0;
					end
				end
				ENC_BIT: begin
					if (tx_fall) begin
						nxt_enc_cnt = 4'h0;
					end else if (enc_cnt_ff == `SIRC_BIT_LAST) begin
						nxt_enc_cnt = 4'h0;
						if (uart_tx_in)
							nxt_enc_state = ENC_IDLE;
					end else begin
						nxt_enc_cnt = enc_cnt_ff + 4'h1;
					end
				end
				default: begin
					nxt_enc_state = ENC_IDLE;
					nxt_enc_cnt   = 4'h0;
				end
			endcase
		end
	end

	assign mod_rise = x16_tick && (nxt_enc_state == ENC_BIT) &&
		(nxt_enc_cnt == `SIRC_ENC_DELAY) && (enc_cnt_ff != `SIRC_ENC_DELAY);

	always @* begin
		nxt_mono_cnt = mono_cnt_ff;
		if (mod_rise && fixed_pulse_select)
			nxt_mono_cnt = `SIRC_MONO_CYC + 3'h1;
		else if (!fixed_pulse_select)
			nxt_mono_cnt = 3'h0;
		else if (xtal_tick && mono_cnt_ff != 3'h0)
			nxt_mono_cnt = mono_cnt_ff - 3'h1;
		if (fixed_pulse_select)
			nxt_ir_tx = (nxt_mono_cnt != 3'h0) &&
				(nxt_mono_cnt <= `SIRC_MONO_CYC);
		else
			nxt_ir_tx = (nxt_enc_state == ENC_BIT) &&
				(nxt_enc_cnt >= `SIRC_ENC_DELAY) &&
				(nxt_enc_cnt <= `SIRC_ENC_LAST);
	end

	always @(posedge core_clk) begin
		if (sm_rst) begin
			enc_state_ff <= ENC_IDLE;
			enc_cnt_ff   <= 4'h0;
			mono_cnt_ff  <= 3'h0;
			ir_tx_out    <= 1'b0;
		end else begin
			enc_state_ff <= nxt_enc_state;
			enc_cnt_ff   <= nxt_enc_cnt;
			mono_cnt_ff  <= nxt_mono_cnt;
			ir_tx_out    <= nxt_ir_tx;
		end
	end

	// ==========================================================
	// Decoder
	always @* begin
		nxt_dec_act = dec_act_ff;
		nxt_dec_cnt = dec_cnt_ff;
		if (x16_tick) begin
			if (rx_fall) begin
				nxt_dec_act = 1'b1;
				nxt_dec_cnt = `SIRC_DEC_LAST;
			end else if (dec_act_ff) begin
				if (dec_cnt_ff == 4'h0)
					nxt_dec_act = 1'b0;
				else
					nxt_dec_cnt = dec_cnt_ff - 4'h1;
			end
		end
	end

	always @(posedge core_clk) begin
		if (sm_rst) begin
			dec_act_ff  <= 1'b0;
			dec_cnt_ff  <= 4'h0;
			uart_rx_out <= 1'b1;
		end else begin
			dec_act_ff  <= nxt_dec_act;
			dec_cnt_ff  <= nxt_dec_cnt;
			uart_rx_out <= !nxt_dec_act;
		end
	end

endmodule

// File: bench/sirc_codec_assertions.sv
// Checker of codec port behaviour
`timescale 1ns/1ps
module sirc_checker (
	input wire        core_clk,
	input wire        rst_n,
	input wire        codec_reset_n,
	input wire        ir_rx_in_n,
	input wire        ir_tx_out,
	input wire        uart_rx_out,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Pulse shapes
	sequence s_pulse;
		ir_tx_out [*3];
	endsequence
	sequence s_space;
		!uart_rx_out [*8];
	endsequence
	idle_reset_a: assert property (
		!codec_reset_n |=> !ir_tx_out && uart_rx_out)
		else $error("Outputs not idle in codec reset");
	tx_width_a: assert property (
		$rose(ir_tx_out) |-> s_pulse)
		else $error("Infrared pulse too short");
	rx_width_a: assert property (
		$fell(uart_rx_out) |-> s_space)
		else $error("Stretched space too short");
	rx_start_a: assert property (
		$fell(ir_rx_in_n) |-> ##[1:1000] !uart_rx_out)
		else $error("No space after receive pulse");
	b_hold_a: assert property ( // see R_BUS
		s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped");
	r_hold_a: assert property ( // see R_BUS
		s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped");
	r_answer_a: assert property ( // see R_BUS
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read not answered");
	r_cause_a: assert property ( // see R_BUS
		$rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("Read answer without request");
endmodule

// File: bench/sirc_far_end.sv
// Model of crystal, external clock, UART and infrared receiver
`timescale 1ns/1ps
module sirc_far_end (
	input  wire core_clk,
	input  wire osc_enable,
	output reg  osc_in,
	output reg  baud_x16_clock,
	output reg  uart_tx_in,
	output reg  ir_rx_in_n
);
	reg       ext_run;
	reg [3:0] ph_ff;
	initial begin
		osc_in = 1'b0;
		baud_x16_clock = 1'b0;
		uart_tx_in = 1'b1;
		ir_rx_in_n = 1'b1;
		ext_run = 1'b0;
		ph_ff = 4'h0;
	end
	// ==========================================
	// Crystal stops while disabled
	always @(posedge core_clk) begin
		ph_ff <= (ph_ff == 4'h9) ? 4'h0 : ph_ff + 4'h1;
		if (osc_enable && ph_ff[0])
			osc_in <= ~osc_in;
		if (ext_run && (ph_ff == 4'h4 || ph_ff == 4'h9))
			baud_x16_clock <= ~baud_x16_clock;
	end
	// ==========================================
	// Line stimulus
	task send(input b, input integer n);
		begin
			uart_tx_in <= b;
			repeat (n) @(posedge core_clk);
		end
	endtask
	task ir_pulse;
		begin
			ir_rx_in_n <= 1'b0;
			repeat (3) @(posedge core_clk);
			ir_rx_in_n <= 1'b1;
		end
	endtask
endmodule

// File: bench/tb.sv
// Testbench of the infrared pulse codec
`timescale 1ns/1ps
`include "sirc_defs.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
	failures++; $display("Error %0s exp %0h got %0h", n, e, s); end end
module tb;
	reg         core_clk, rst_n, codec_reset_n;
	reg  [7:0]  s_axi_awaddr, s_axi_araddr;
	reg  [31:0] s_axi_wdata;
	reg  [3:0]  s_axi_wstrb;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg         s_axi_arvalid, s_axi_rready;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire        s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        osc_in, baud_x16_clock, uart_tx_in, ir_rx_in_n;
	wire        ir_tx_out, uart_rx_out, osc_enable;
	integer     failures, compares, i, cyc, hi, lo, tw, tn, rw, sp, lr;
	integer     dv [0:7] = '{2, 4, 12, 24, 6, 48, 96, 1};
	reg  [31:0] d;
	reg  [1:0]  resp;
	reg         ok, slow;
	sirc_codec dut (.*);
	sirc_far_end far (.*);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ==========================================
	// Pulse width monitor
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (ir_tx_out === 1'b1) begin
			if (hi == 0) begin
				sp = cyc - lr;
				lr = cyc;
			end
			hi = hi + 1;
		end else if (hi != 0) begin
			tw = hi;
			tn = tn + 1;
			hi = 0;
		end
		if (uart_rx_out === 1'b0)
			lo = lo + 1;
		else if (lo != 0) begin
			rw = lo;
			lo = 0;
		end
	end
	// ==========================================
	// Bus tasks
	task wr(input [7:0] a, input [31:0] v);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= !slow;
			ok = 1'b0;
			while (!ok) begin
				@(posedge core_clk);
				if (s_axi_awvalid && s_axi_awready)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wvalid && s_axi_wready)
					s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid && s_axi_bready) begin
					ok = 1'b1;
					resp = s_axi_bresp;
					s_axi_bready <= 1'b0;
				end else if (s_axi_bvalid)
					s_axi_bready <= 1'b1;
			end
			@(posedge core_clk);
		end
	endtask
	task rd(input [7:0] a);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= !slow;
			ok = 1'b0;
			while (!ok) begin
				@(posedge core_clk);
				if (s_axi_arvalid && s_axi_arready)
					s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid && s_axi_rready) begin
					ok = 1'b1;
					d = s_axi_rdata;
					resp = s_axi_rresp;
					s_axi_rready <= 1'b0;
				end else if (s_axi_rvalid)
					s_axi_rready <= 1'b1;
			end
			@(posedge core_clk);
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// ==========================================
	// Tests
	initial begin
		{failures, compares, cyc, hi, lo, tw, tn, rw, sp, lr} = 0;
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr} = 10'h000;
		{s_axi_araddr, s_axi_wdata} = 40'h0;
		codec_reset_n = 1'b1;
		slow = 1'b0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		`CHK("ir_tx_out", 1'b0, ir_tx_out)
		`CHK("uart_rx_out", 1'b1, uart_rx_out)
		rd(`SIRC_CTRL_OFS);
		`CHK("ctrl", 32'h0, d)
		slow = 1'b1;
		rd(8'h08);
		`CHK("bad resp", `SIRC_RESP_SLVERR, resp) // see R_BUS
		`CHK("bad data", 32'h0, d) // see R_BUS
		wr(8'h0c, 32'h3f);
		`CHK("bad wr resp", `SIRC_RESP_SLVERR, resp) // see R_BUS
		slow = 1'b0;
		wr(`SIRC_STAT_OFS, 32'h3f);
		`CHK("stat wr resp", `SIRC_RESP_OKAY, resp) // see R_BUS
		s_axi_wstrb <= 4'he;
		wr(`SIRC_CTRL_OFS, 32'h3f);
		s_axi_wstrb <= 4'hf;
		rd(`SIRC_CTRL_OFS);
		`CHK("masked wr", 32'h0, d) // see R_BUS
		rd(`SIRC_STAT_OFS);
		`CHK("status", 32'h11, d)
		$display("test reset done");
		wr(`SIRC_CTRL_OFS, 32'h20);
		`CHK("osc sleep", 1'b0, osc_enable)
		wr(`SIRC_CTRL_OFS, 32'h08);
		`CHK("osc ext", 1'b0, osc_enable)
		wr(`SIRC_CTRL_OFS, 32'h00);
		`CHK("osc run", 1'b1, osc_enable)
		$display("test oscillator done");
		for (i = 0; i < 8; i = i + 1) begin
			wr(`SIRC_CTRL_OFS, i);
			tn = 0;
			far.send(1'b0, 128 * dv[i]);
			far.send(1'b1, 128 * dv[i]);
			`CHK("pulses", 2, tn)
			`CHK("width", 12 * dv[i], tw)
			`CHK("spacing", 64 * dv[i], sp)
		end
		$display("test encoder rates done");
		for (i = 0; i < 2; i = i + 1) begin
			wr(`SIRC_CTRL_OFS, 32'h10 | (5 * i));
			tn = 0;
			far.send(1'b0, 64 * dv[5 * i]);
			far.send(1'b1, 64 * dv[5 * i]);
			`CHK("mono pulses", 1, tn)
			`CHK("mono width", 24, tw)
		end
		$display("test fixed pulse done");
		wr(`SIRC_CTRL_OFS, 32'h00);
		far.ir_pulse;
		repeat (200) @(posedge core_clk);
		`CHK("stretch", 128, rw)
		wr(`SIRC_CTRL_OFS, 32'h08);
		far.ext_run <= 1'b1;
		far.ir_pulse;
		repeat (300) @(posedge core_clk);
		`CHK("ext stretch", 160, rw)
		far.ext_run <= 1'b0;
		wr(`SIRC_CTRL_OFS, 32'h00);
		far.ir_pulse;
		repeat (40) @(posedge core_clk);
		codec_reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		codec_reset_n <= 1'b1;
		`CHK("codec reset", 1'b1, uart_rx_out)
		$display("test decoder done");
		wrap_up;
	end
	initial begin
		repeat (90000) @(posedge core_clk);
		failures++;
		wrap_up;
	end
endmodule
bind sirc_codec sirc_checker chk (.*);
